// ==== include/cbrmx_map.svh ====
`ifndef CBRMX_MAP_SVH
`define CBRMX_MAP_SVH
// APB register byte offsets
`define CBRMX_CTRL_OFS 12'h000
`define CBRMX_STATUS_OFS 12'h004
`define CBRMX_EVENT_OFS 12'h008
`define CBRMX_IRQ_STAT_OFS 12'h00c
`define CBRMX_IRQ_MASK_OFS 12'h010
`define CBRMX_CFG_ID_OFS 12'h014
// Control fields
`define CBRMX_CTRL_BOOT_GATE 0
`define CBRMX_CTRL_BOOT_OK 1
`define CBRMX_CTRL_RESET 32'h0000_0000
// Event bits: orientation, display mode, high-speed link, usb3, connection
`define CBRMX_EV_ORIENT 0
`define CBRMX_EV_DISP 1
`define CBRMX_EV_HSLINK 2
`define CBRMX_EV_USB3 3
`define CBRMX_EV_CONN 4
`define CBRMX_EV_W 5
// Interrupt status bits
`define CBRMX_IRQ_LOAD_DONE 0
`define CBRMX_IRQ_RST_REL 1
`define CBRMX_IRQ_EV_CHG 2
`define CBRMX_IRQ_W 3
// Companion serial target address (7 bit)
`define CBRMX_SERIAL_ADDR 7'h38
// Supply settle time before reset release
`define CBRMX_SETTLE_US 100
`define CBRMX_CLK_MHZ 100
`define CBRMX_SETTLE_CYC (`CBRMX_SETTLE_US * `CBRMX_CLK_MHZ)
`endif

// ==== include/cbrmx_pkg.sv ====
package cbrmx_pkg;
    typedef enum logic [1:0] {
        CBRMX_ST_LOAD,
        CBRMX_ST_WAIT_SUPPLY,
        CBRMX_ST_SETTLE,
        CBRMX_ST_RUN
    } cbrmx_state_t;
endpackage

// ==== hw/cbrmx_settle_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cbrmx_map.svh"
module cbrmx_settle_timer #(
    parameter int unsigned SETTLE_CYC = `CBRMX_SETTLE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic run,
    output logic done
);
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    localparam logic [15:0] LAST = 16'(SETTLE_CYC - 1);

    assign done = run && (cnt_r == LAST);
    // Any dip of run restarts the full wait
    assign cnt_nxt = !run ? 16'h0000 : (done ? cnt_r : cnt_r + 16'h0001);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

// ==== hw/cbrmx_top.sv ====
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "cbrmx_map.svh"
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Own config load precedes companion flash access
// - Companion held in reset during load
// - First output dedicated to companion reset
// - Reset release ANDed with companion supply
// - Release at least 100 us after supply
// - Serial port answers at address 0x38
// - Connection raises companion interrupt line
// - Events drive sideband selects and enables
// - Events drive super-speed flip and controls
module cbrmx_top #(
    parameter int unsigned SETTLE_CYC = `CBRMX_SETTLE_CYC
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic COMPANION_RST_LINE,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Configuration load and flash arbitration
    input wire logic CONFIG_LOAD_DONE,
    output logic OWN_FLASH_GRANT,
    // Companion
    input wire logic COMPANION_SUPPLY_GOOD,
    output logic COMPANION_RST_LINE_N,
    output logic COMPANION_INT,
    output logic [6:0] COMPANION_SERIAL_ADDR,
    input wire logic [6:0] SERIAL_REQ_ADDR,
    output logic SERIAL_ADDR_ACK,
    // Port events
    input wire logic EV_ORIENT,
    input wire logic EV_DISP,
    input wire logic EV_HSLINK,
    input wire logic EV_USB3,
    input wire logic EV_CONN,
    // Sideband mux
    output logic SIDEBAND_SELECT_A,
    output logic SIDEBAND_SELECT_B,
    output logic SIDEBAND_INPUT_SELECT_A,
    output logic SIDEBAND_INPUT_SELECT_B,
    output logic AUX_PATH_ENABLE,
    output logic LOWSPEED_PATH_ENABLE,
    // Super-speed mux
    output logic SS_FLIP,
    output logic SS_USB3_SELECT,
    output logic SS_DISPLAY_SELECT,
    // Interrupt
    output logic IRQ
);
    //////////////////////////////////////////////////////////////////////////
    // Reset synchroniser
    logic rst_s1_r;
    logic rst_n;
    always_ff @(posedge REF_CLK or negedge COMPANION_RST_LINE) begin
        if (!COMPANION_RST_LINE) begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Registers
    logic [31:0] ctrl_r;
    logic [`CBRMX_IRQ_W-1:0] irq_stat_r;
    logic [`CBRMX_IRQ_W-1:0] irq_stat_nxt;
    logic [`CBRMX_IRQ_W-1:0] irq_mask_r;
    logic [`CBRMX_EV_W-1:0] ev_r;
    logic [`CBRMX_EV_W-1:0] ev_nxt;
    logic [31:0] prdata_nxt;
    cbrmx_pkg::cbrmx_state_t st_r;
    cbrmx_pkg::cbrmx_state_t st_nxt;

    wire apb_acc = PSEL && PENABLE;
    wire apb_wr = apb_acc && PWRITE;
    wire apb_rd = apb_acc && !PWRITE;
    wire hit_ctrl = PADDR == `CBRMX_CTRL_OFS;
    wire hit_status = PADDR == `CBRMX_STATUS_OFS;
    wire hit_event = PADDR == `CBRMX_EVENT_OFS;
    wire hit_istat = PADDR == `CBRMX_IRQ_STAT_OFS;
    wire hit_imask = PADDR == `CBRMX_IRQ_MASK_OFS;
    wire hit_cfg = PADDR == `CBRMX_CFG_ID_OFS;
    wire hit_any = hit_ctrl || hit_status || hit_event || hit_istat || hit_imask || hit_cfg;
    wire boot_gate = ctrl_r[`CBRMX_CTRL_BOOT_GATE];
    wire boot_ok = ctrl_r[`CBRMX_CTRL_BOOT_OK];

    // Zero wait states; unmapped address answers with error
    assign PREADY = 1'b1;
    assign PSLVERR = apb_acc && !hit_any;

    //////////////////////////////////////////////////////////////////////////
    // Reset sequencer
    logic settle_done;
    wire supply_ok = COMPANION_SUPPLY_GOOD;
    wire host_allow = !boot_gate || boot_ok;

    cbrmx_settle_timer #(
        .SETTLE_CYC(SETTLE_CYC)
    ) u_settle (
        .clk(REF_CLK),
        .rst_n(rst_n),
        .run(st_r == cbrmx_pkg::CBRMX_ST_SETTLE && supply_ok),
        .done(settle_done)
    );

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            cbrmx_pkg::CBRMX_ST_LOAD: begin
                if (CONFIG_LOAD_DONE) begin
                    st_nxt = cbrmx_pkg::CBRMX_ST_WAIT_SUPPLY;
                end
            end
            cbrmx_pkg::CBRMX_ST_WAIT_SUPPLY: begin
                if (supply_ok && host_allow) begin
                    st_nxt = cbrmx_pkg::CBRMX_ST_SETTLE;
                end
            end
            cbrmx_pkg::CBRMX_ST_SETTLE: begin
                // Supply loss restarts the settle wait
                if (!supply_ok || !host_allow) begin
                    st_nxt = cbrmx_pkg::CBRMX_ST_WAIT_SUPPLY;
                end else if (settle_done) begin
                    st_nxt = cbrmx_pkg::CBRMX_ST_RUN;
                end
            end
            cbrmx_pkg::CBRMX_ST_RUN: begin
                if (!supply_ok || !host_allow) begin
                    st_nxt = cbrmx_pkg::CBRMX_ST_WAIT_SUPPLY;
                end
            end
            default: st_nxt = cbrmx_pkg::CBRMX_ST_LOAD;
        endcase
    end

    // Gated by live supply so a brown-out asserts reset at once
    logic rst_rel_r;
    wire rst_rel_nxt = (st_nxt == cbrmx_pkg::CBRMX_ST_RUN) && supply_ok;

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= cbrmx_pkg::CBRMX_ST_LOAD;
            rst_rel_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            rst_rel_r <= rst_rel_nxt;
        end
    end

    assign COMPANION_RST_LINE_N = rst_rel_r && supply_ok;
    assign OWN_FLASH_GRANT = st_r == cbrmx_pkg::CBRMX_ST_LOAD;

    //////////////////////////////////////////////////////////////////////////
    // Companion serial port and event muxes
    assign COMPANION_SERIAL_ADDR = `CBRMX_SERIAL_ADDR;
    assign SERIAL_ADDR_ACK = SERIAL_REQ_ADDR == `CBRMX_SERIAL_ADDR;
    assign SIDEBAND_INPUT_SELECT_A = 1'b1;
    assign SIDEBAND_INPUT_SELECT_B = 1'b0;

    assign ev_nxt = {EV_CONN, EV_USB3, EV_HSLINK, EV_DISP, EV_ORIENT};

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ev_r <= '0;
        end else begin
            ev_r <= ev_nxt;
        end
    end

    assign SIDEBAND_SELECT_A = ev_r[`CBRMX_EV_ORIENT];
    assign SIDEBAND_SELECT_B = ev_r[`CBRMX_EV_ORIENT];
    assign AUX_PATH_ENABLE = ev_r[`CBRMX_EV_DISP];
    assign LOWSPEED_PATH_ENABLE = ev_r[`CBRMX_EV_HSLINK];
    assign SS_FLIP = ev_r[`CBRMX_EV_ORIENT];
    assign SS_USB3_SELECT = ev_r[`CBRMX_EV_USB3];
    assign SS_DISPLAY_SELECT = ev_r[`CBRMX_EV_DISP];
    assign COMPANION_INT = ev_r[`CBRMX_EV_CONN];

    //////////////////////////////////////////////////////////////////////////
    // Interrupt status; set wins over read-clear
    logic load_done_d_r;
    logic [`CBRMX_IRQ_W-1:0] irq_set;
    wire load_rise = CONFIG_LOAD_DONE && !load_done_d_r && st_r == cbrmx_pkg::CBRMX_ST_LOAD;
    wire rel_rise = rst_rel_nxt && !rst_rel_r;
    wire ev_chg = ev_nxt != ev_r;
    assign irq_set = {ev_chg, rel_rise, load_rise};
    // Clear only what the read returned; a bit set after the setup edge must survive
    wire [`CBRMX_IRQ_W-1:0] istat_clr = (apb_rd && hit_istat) ? PRDATA[`CBRMX_IRQ_W-1:0] : '0;
    assign irq_stat_nxt = (irq_stat_r & ~istat_clr) | irq_set;
    assign IRQ = |(irq_stat_r & irq_mask_r);

    always_comb begin
        prdata_nxt = 32'h0000_0000;
        if (hit_ctrl) prdata_nxt = ctrl_r;
        if (hit_status) prdata_nxt = {27'h0, supply_ok, COMPANION_RST_LINE_N, st_r, CONFIG_LOAD_DONE};
        if (hit_event) prdata_nxt = {27'h0, ev_r};
        if (hit_istat) prdata_nxt = {29'h0, irq_stat_r};
        if (hit_imask) prdata_nxt = {29'h0, irq_mask_r};
        if (hit_cfg) prdata_nxt = {25'h0, `CBRMX_SERIAL_ADDR};
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `CBRMX_CTRL_RESET;
            irq_mask_r <= '0;
            irq_stat_r <= '0;
            load_done_d_r <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else begin
            if (apb_wr && hit_ctrl) ctrl_r <= {30'h0, PWDATA[1:0]};
            if (apb_wr && hit_imask) irq_mask_r <= PWDATA[`CBRMX_IRQ_W-1:0];
            irq_stat_r <= irq_stat_nxt;
            load_done_d_r <= CONFIG_LOAD_DONE;
            if (PSEL && !PENABLE && !PWRITE) PRDATA <= prdata_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Assertions
    a_hold_in_load: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        st_r == cbrmx_pkg::CBRMX_ST_LOAD |-> !COMPANION_RST_LINE_N)
        else $error("companion released during load");
    a_supply_gate: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        !COMPANION_SUPPLY_GOOD |-> !COMPANION_RST_LINE_N)
        else $error("companion released without supply");
    a_settle_wait: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        $rose(COMPANION_RST_LINE_N) |-> $past(supply_ok, 2) && $past(st_r) == cbrmx_pkg::CBRMX_ST_SETTLE)
        else $error("release without settle");
    a_serial_ack: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        SERIAL_ADDR_ACK == (SERIAL_REQ_ADDR == 7'h38))
        else $error("serial address ack wrong");
    a_conn_int: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        EV_CONN |=> COMPANION_INT)
        else $error("connection did not raise interrupt");
    a_sb_orient: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        1'b1 |=> SIDEBAND_SELECT_A == $past(EV_ORIENT) && SIDEBAND_SELECT_B == $past(EV_ORIENT))
        else $error("sideband select mismatch");
    a_ss_ctrl: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        1'b1 |=> SS_USB3_SELECT == $past(EV_USB3) && SS_DISPLAY_SELECT == $past(EV_DISP))
        else $error("super-speed control mismatch");
    a_boot_gate: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        boot_gate && !boot_ok |-> ##1 !COMPANION_RST_LINE_N)
        else $error("release before boot ok");
    a_load_first: assert property (@(posedge REF_CLK) disable iff (!rst_n)
        COMPANION_RST_LINE_N |-> !OWN_FLASH_GRANT)
        else $error("flash shared with companion");
    c_release: cover property (@(posedge REF_CLK) disable iff (!rst_n) $rose(COMPANION_RST_LINE_N));
    c_brownout: cover property (@(posedge REF_CLK) disable iff (!rst_n) $fell(COMPANION_RST_LINE_N));
    c_irq: cover property (@(posedge REF_CLK) disable iff (!rst_n) $rose(IRQ));
endmodule
`default_nettype wire

// ==== test/cbrmx_companion_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module cbrmx_companion_model (
    // Clock
    input wire logic clk,
    // Lines from the device
    input wire logic supply_good,
    input wire logic rst_line_n,
    input wire logic int_line,
    // Serial request and settle measure
    output logic [6:0] req_addr,
    output logic [15:0] powered_cycles
);
    ////////////////////////////////////////
    initial req_addr = 7'h39;
    initial powered_cycles = 16'h0000;
    // Powered time spent in reset; a dropped rail restarts the count
    always @(posedge clk) begin
        if (!supply_good) begin
            powered_cycles <= 16'h0000;
        end else if (!rst_line_n) begin
            powered_cycles <= powered_cycles + 16'h0001;
        end
    end
    // Idle address toggles so a stale value never looks like a read
    always @(posedge clk) begin
        if (int_line) begin
            req_addr <= 7'h38;
        end else begin
            req_addr <= (req_addr == 7'h39) ? 7'h46 : 7'h39;
        end
    end
endmodule
`default_nettype wire

// ==== test/cbrmx_top_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cbrmx_map.svh"
module cbrmx_top_tb;
    localparam int unsigned SETTLE = 20;
    typedef struct packed {logic [4:0] ev; logic [7:0] exp;} cbrmx_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, load_done = 1'b0, grant, supply = 1'b1;
    logic rst_line_n, int_line, ack, sa, sb, isa, isb, aux, ls, flip, u3, dp, irq;
    logic [6:0] own_addr, req_addr;
    logic [4:0] ev = 5'h00;
    logic [15:0] powered;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;
    cbrmx_row_t rows [6] = '{'{5'h01, 8'hc8}, '{5'h02, 8'h22}, '{5'h04, 8'h10},
                             '{5'h08, 8'h04}, '{5'h10, 8'h01}, '{5'h1f, 8'hff}};
    cbrmx_top #(.SETTLE_CYC(SETTLE)) u_dut (.REF_CLK(clk), .COMPANION_RST_LINE(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .CONFIG_LOAD_DONE(load_done), .OWN_FLASH_GRANT(grant),
        .COMPANION_SUPPLY_GOOD(supply), .COMPANION_RST_LINE_N(rst_line_n), .COMPANION_INT(int_line),
        .COMPANION_SERIAL_ADDR(own_addr), .SERIAL_REQ_ADDR(req_addr), .SERIAL_ADDR_ACK(ack),
        .EV_ORIENT(ev[0]), .EV_DISP(ev[1]), .EV_HSLINK(ev[2]), .EV_USB3(ev[3]), .EV_CONN(ev[4]),
        .SIDEBAND_SELECT_A(sa), .SIDEBAND_SELECT_B(sb), .SIDEBAND_INPUT_SELECT_A(isa),
        .SIDEBAND_INPUT_SELECT_B(isb), .AUX_PATH_ENABLE(aux), .LOWSPEED_PATH_ENABLE(ls),
        .SS_FLIP(flip), .SS_USB3_SELECT(u3), .SS_DISPLAY_SELECT(dp), .IRQ(irq));
    cbrmx_companion_model u_comp (.clk(clk), .supply_good(supply), .rst_line_n(rst_line_n),
        .int_line(int_line), .req_addr(req_addr), .powered_cycles(powered));
    ////////////////////////////////////////
    always #5 clk = ~clk;
    // Cut a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_release();
        n = 0;
        while (rst_line_n !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        #1;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b1, `CBRMX_IRQ_MASK_OFS, 32'h4);
        foreach (rows[i]) begin
            @(posedge clk);
            ev <= rows[i].ev;
            repeat (3) @(posedge clk);
            #1;
            check("mux", {sa, sb, aux, ls, flip, u3, dp, int_line, isa, isb}, {rows[i].exp, 2'b10});
            check("ack", ack, rows[i].exp[0]);
        end
        check("irq", irq, 1);
        apb(1'b0, `CBRMX_IRQ_STAT_OFS, 32'h0);
        check("istat", rd, 32'h4);
        @(posedge clk);
        #1;
        check("irq clr", irq, 0);
        apb(1'b0, `CBRMX_EVENT_OFS, 32'h0);
        check("event", rd, 32'h1f);
        apb(1'b0, `CBRMX_CFG_ID_OFS, 32'h0);
        check("id", rd, 32'h38);
        check("own addr", own_addr, 7'h38);
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped", {err, rd[30:0]}, 32'h80000000);
        #1;
        check("held", rst_line_n, 0);
        check("grant", grant, 1);
        @(posedge clk);
        load_done <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("grant off", grant, 0);
        wait_release();
        check("release", rst_line_n, 1);
        apb(1'b0, `CBRMX_STATUS_OFS, 32'h0);
        check("status", rd, 32'h1f);
        apb(1'b0, `CBRMX_IRQ_STAT_OFS, 32'h0);
        check("istat2", rd, 32'h3);
        check("masked", irq, 0);
        @(posedge clk);
        supply <= 1'b0;
        #1;
        check("drop", rst_line_n, 0);
        repeat (5) @(posedge clk);
        supply <= 1'b1;
        wait_release();
        check("settle", (powered >= SETTLE && powered <= SETTLE + 4), 1);
        // Host holds the companion until it reports a good boot
        apb(1'b1, `CBRMX_CTRL_OFS, 32'h1);
        supply <= 1'b0;
        repeat (5) @(posedge clk);
        supply <= 1'b1;
        repeat (3 * SETTLE) @(posedge clk);
        #1;
        check("gated", rst_line_n, 0);
        apb(1'b1, `CBRMX_CTRL_OFS, 32'h3);
        wait_release();
        check("boot ok", rst_line_n, 1);
        complete_run();
    end
endmodule
`default_nettype wire
